// ==== rtl/conv_ctrl_regs.vh ====
// register offsets, field positions, reset values and timing counts for the converter control block
// How it works
// - alignment bit one gives left-justified result
// - alignment change shows at once in data
// - selector latched only at conversion completion
// - codes 0-7 single inputs, 30 bandgap, 31 ground
// - codes 8-29 pick differential pair and gain
// - clearing enable aborts conversion, no result
// - single mode: each start, one conversion
// - free running: start begins, rest follow
// - first conversion 25 cycles, later 13
// - start reads one while busy, zero ignored
// - auto trigger starts on trigger rising edge
// - done flag set as result is stored
// - irq only when flag, enable, global set
// - flag cleared by vector taken or one-write
// - converter clock divided by divider code
// - low byte read freezes data till high
// - free running code makes no trigger event
`ifndef CONV_CTRL_REGS_VH
`define CONV_CTRL_REGS_VH

// register byte addresses (index times four, printed offsets are not word aligned)
`define IDX_RESULT_LOW 8'h78
`define IDX_RESULT_HIGH 8'h79
`define IDX_CONTROL_STATUS 8'h7a
`define IDX_TRIGGER_SELECT 8'h7b
`define IDX_INPUT_SELECT 8'h7c
`define ADDR_RESULT_LOW 10'h1e0
`define ADDR_RESULT_HIGH 10'h1e4
`define ADDR_CONTROL_STATUS 10'h1e8
`define ADDR_TRIGGER_SELECT 10'h1ec
`define ADDR_INPUT_SELECT 10'h1f0

// control/status fields
`define CS_ENABLE 7
`define CS_START 6
`define CS_AUTO 5
`define CS_DONE 4
`define CS_IRQ_EN 3
`define CS_DIV_HI 2
`define CS_DIV_LO 0

// input select fields
`define IS_LEFT 5
`define IS_SEL_HI 4
`define IS_SEL_LO 0

// reset values
`define RST_CONTROL_STATUS 8'h00
`define RST_INPUT_SELECT 8'h00
`define RST_TRIGGER_SELECT 3'h0

// conversion lengths in converter clock cycles, then the free running trigger code
`define FIRST_CONV_CYCLES 5'h19
`define NORMAL_CONV_CYCLES 5'h0d
`define TRIG_FREE_RUNNING 3'h0

`endif

// ==== rtl/conv_clock_divider.v ====
// converter clock tick generator dividing the system clock
`timescale 1ns/10ps
module conv_clock_divider (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_ce,
  // control
  input wire i_run,
  input wire [2:0] i_div_sel,
  // converter clock tick, one system cycle wide
  output reg o_tick
);
  reg [6:0] count;

  // divisor minus one: codes 0 and 1 give 2, then doubling to 128
  function [6:0] div_limit;
    input [2:0] sel;
    begin
      if (sel == 3'h0)
        div_limit = 7'h01;
      else
        div_limit = (7'h01 << sel) - 7'h01;
    end
  endfunction

  // counter held at zero while off so every enable starts the same phase
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      count <= 7'h00;
      o_tick <= 1'b0;
    end
    else if (i_ce)
    begin
      if (!i_run)
      begin
        count <= 7'h00;
        o_tick <= 1'b0;
      end
      else if (count >= div_limit(i_div_sel))
      begin
        count <= 7'h00;
        o_tick <= 1'b1;
      end
      else
      begin
        count <= count + 7'h01;
        o_tick <= 1'b0;
      end
    end
  end
endmodule // conv_clock_divider

// ==== rtl/trigger_edge_detect.v ====
// synchroniser and rising-edge detector for the auto trigger sources
`timescale 1ns/10ps
`include "conv_ctrl_regs.vh"
module trigger_edge_detect (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_ce,
  // trigger sources, bit 0 unused (free running)
  input wire [7:0] i_sources,
  input wire [2:0] i_select,
  // edge pulse
  output wire o_edge
);
  reg [7:0] sync1;
  reg [7:0] sync2;
  reg [7:0] sync3;
  reg [7:0] level;
  reg prev_level;
  wire [7:0] next_level;
  wire selected;

  // a change counts only once the last two stages agree
  assign next_level = (sync2 & sync3) | (level & (sync2 | sync3));
  assign selected = level[i_select];
  // switching source can make an edge, but never into free running
  assign o_edge = selected & !prev_level & (i_select != `TRIG_FREE_RUNNING);

  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      sync3 <= 8'h00;
      level <= 8'h00;
      prev_level <= 1'b0;
    end
    else if (i_ce)
    begin
      sync1 <= i_sources;
      sync2 <= sync1;
      sync3 <= sync2;
      level <= next_level;
      prev_level <= selected;
    end
  end
endmodule // trigger_edge_detect

// ==== rtl/conv_ctrl.v ====
// converter channel and conversion control with a classic wishbone register slave
`timescale 1ns/10ps
`include "conv_ctrl_regs.vh"
module conv_ctrl (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_ce,
  // wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [9:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // processor side
  input wire i_global_irq_en,
  input wire i_irq_vector_taken,
  output wire o_done_irq,
  // trigger sources, bit n for source code n
  input wire [7:0] i_trigger_sources,
  // converter core
  output reg o_conv_power,
  output reg o_conv_clk_tick,
  output reg o_sample_start,
  output reg o_conv_init,
  output reg [4:0] o_channel_gain_selector,
  output reg [3:0] o_pos_input,
  output reg [3:0] o_neg_input,
  output reg [1:0] o_gain_code,
  output reg o_differential,
  input wire [9:0] i_conv_result
);
  // one-hot states
  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;

  reg [1:0] state;
  reg converter_enable_bit;
  reg auto_trigger_enable;
  reg conversion_done_flag;
  reg done_irq_enable;
  reg [2:0] clock_divider_select;
  reg left_justify_bit;
  reg [4:0] channel_gain_selector;
  reg [1:0] reference_bits;
  reg [2:0] trigger_source_select;
  reg first_pending;
  reg start_request;
  reg [4:0] cycles_left;
  reg [9:0] result;
  reg [9:0] shown_result;
  reg frozen;
  wire tick;
  wire trig_edge;
  wire bus_req;
  wire wr;
  wire rd;
  wire wr_cs;
  wire [7:0] wd;
  wire done_now;
  wire [15:0] data_reg;
  wire free_running;

  // returns positive input, negative input, gain code, differential for a selector
  // gain code: 0 none, 1 x1, 2 x10, 3 x200
  function [10:0] route;
    input [4:0] s;
    begin
      if (s[4:3] == 2'b00)
        route = {1'b0, s[2:0], 4'h0, 2'b00, 1'b0};
      else if (s == 5'h1e)
        route = {4'h8, 4'h0, 2'b00, 1'b0};
      else if (s == 5'h1f)
        route = {4'h9, 4'h0, 2'b00, 1'b0};
      else if (s[4:3] == 2'b01)
        route = {2'b00, s[2], s[0], 2'b00, s[2], 1'b0, s[1] ? 2'b11 : 2'b10, 1'b1};
      else if (s[4:3] == 2'b10)
        route = {1'b0, s[2:0], 4'h1, 2'b01, 1'b1};
      else
        route = {2'b00, s[1:0] + 2'b00, 4'h2, 2'b01, 1'b1};
    end
  endfunction

  conv_clock_divider u_div (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_run(converter_enable_bit),
    .i_div_sel(clock_divider_select),
    .o_tick(tick)
  );

  trigger_edge_detect u_trig (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_sources(i_trigger_sources),
    .i_select(trigger_source_select),
    .o_edge(trig_edge)
  );

  // bus decode, one wait state then ack
  assign bus_req = i_wb_cyc & i_wb_stb & !o_wb_ack;
  assign wr = bus_req & i_wb_we & i_wb_sel[0];
  assign rd = bus_req & !i_wb_we;
  assign wd = i_wb_dat[7:0];
  assign wr_cs = wr & (i_wb_adr == `ADDR_CONTROL_STATUS);
  assign done_now = (state == ST_CONV) & tick & (cycles_left == 5'h01) & converter_enable_bit;
  assign free_running = auto_trigger_enable & (trigger_source_select == `TRIG_FREE_RUNNING);
  assign o_done_irq = conversion_done_flag & done_irq_enable & i_global_irq_en;

  // layout follows the alignment bit combinationally, no latching
  assign data_reg = left_justify_bit ? {shown_result, 6'h00} : {6'h00, shown_result};

  // wishbone answer
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end
    else if (i_ce)
    begin
      o_wb_ack <= bus_req;
      if (rd)
      begin
        if (i_wb_adr == `ADDR_RESULT_LOW)
          o_wb_dat <= {24'h000000, data_reg[7:0]};
        else if (i_wb_adr == `ADDR_RESULT_HIGH)
          o_wb_dat <= {24'h000000, data_reg[15:8]};
        else if (i_wb_adr == `ADDR_CONTROL_STATUS)
          o_wb_dat <= {24'h000000, converter_enable_bit, state == ST_CONV || start_request,
            auto_trigger_enable, conversion_done_flag, done_irq_enable, clock_divider_select};
        else if (i_wb_adr == `ADDR_TRIGGER_SELECT)
          o_wb_dat <= {29'h00000000, trigger_source_select};
        else if (i_wb_adr == `ADDR_INPUT_SELECT)
          o_wb_dat <= {24'h000000, reference_bits, left_justify_bit, channel_gain_selector};
        else
          o_wb_dat <= 32'h00000000;
      end
    end
  end

  // register writes; the done flag set wins over a clear in the same cycle
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      converter_enable_bit <= 1'b0;
      auto_trigger_enable <= 1'b0;
      conversion_done_flag <= 1'b0;
      done_irq_enable <= 1'b0;
      clock_divider_select <= 3'h0;
      left_justify_bit <= 1'b0;
      channel_gain_selector <= 5'h00;
      reference_bits <= 2'b00;
      trigger_source_select <= `RST_TRIGGER_SELECT;
    end
    else if (i_ce)
    begin
      if (wr_cs)
      begin
        converter_enable_bit <= wd[`CS_ENABLE];
        auto_trigger_enable <= wd[`CS_AUTO];
        done_irq_enable <= wd[`CS_IRQ_EN];
        clock_divider_select <= wd[`CS_DIV_HI:`CS_DIV_LO];
      end
      if (wr & (i_wb_adr == `ADDR_INPUT_SELECT))
      begin
        left_justify_bit <= wd[`IS_LEFT];
        channel_gain_selector <= wd[`IS_SEL_HI:`IS_SEL_LO];
        reference_bits <= wd[7:6];
      end
      if (wr & (i_wb_adr == `ADDR_TRIGGER_SELECT))
        trigger_source_select <= wd[2:0];
      if (done_now)
        conversion_done_flag <= 1'b1;
      else if (i_irq_vector_taken | (wr_cs & wd[`CS_DONE]))
        conversion_done_flag <= 1'b0;
    end
  end

  // start requests from software, trigger or free running chain
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      start_request <= 1'b0;
    else if (i_ce)
    begin
      if (wr_cs & !wd[`CS_ENABLE])
        start_request <= 1'b0;
      else if (wr_cs & wd[`CS_START])
        start_request <= 1'b1;
      else if (auto_trigger_enable & trig_edge & converter_enable_bit)
        start_request <= 1'b1;
      else if (done_now & free_running)
        start_request <= 1'b1;
      else if (state == ST_CONV)
        start_request <= 1'b0;
    end
  end

  // conversion sequencer, counting converter clock ticks
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= ST_IDLE;
      cycles_left <= 5'h00;
      first_pending <= 1'b1;
      result <= 10'h000;
      o_channel_gain_selector <= 5'h00;
      o_sample_start <= 1'b0;
      o_conv_init <= 1'b0;
    end
    else if (i_ce)
    begin
      o_sample_start <= 1'b0;
      if (!converter_enable_bit)
      begin
        state <= ST_IDLE;
        first_pending <= 1'b1;
        o_conv_init <= 1'b0;
      end
      else
        case (state)
          ST_IDLE:
          begin
            if (start_request)
            begin
              state <= ST_CONV;
              cycles_left <= first_pending ? `FIRST_CONV_CYCLES : `NORMAL_CONV_CYCLES;
              o_conv_init <= first_pending;
              first_pending <= 1'b0;
              o_sample_start <= 1'b1;
            end
          end
          ST_CONV:
          begin
            if (tick)
            begin
              cycles_left <= cycles_left - 5'h01;
              if (cycles_left == 5'h01)
              begin
                state <= ST_IDLE;
                result <= i_conv_result;
                o_conv_init <= 1'b0;
                o_channel_gain_selector <= channel_gain_selector;
              end
            end
          end
          default:
            state <= ST_IDLE;
        endcase
    end
  end

  // data register held after a low read until the high byte is read
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      frozen <= 1'b0;
      shown_result <= 10'h000;
    end
    else if (i_ce)
    begin
      if (rd & (i_wb_adr == `ADDR_RESULT_LOW))
        frozen <= 1'b1;
      else if (rd & (i_wb_adr == `ADDR_RESULT_HIGH))
        frozen <= 1'b0;
      if (!frozen)
        shown_result <= result;
    end
  end

  // power, tick and analogue steering outputs registered, the steering from the latched selector
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_conv_power <= 1'b0;
      o_conv_clk_tick <= 1'b0;
      o_pos_input <= 4'h0;
      o_neg_input <= 4'h0;
      o_gain_code <= 2'b00;
      o_differential <= 1'b0;
    end
    else if (i_ce)
    begin
      o_conv_power <= converter_enable_bit;
      o_conv_clk_tick <= tick;
      {o_pos_input, o_neg_input, o_gain_code, o_differential} <= route(o_channel_gain_selector);
    end
  end
endmodule // conv_ctrl

// ==== tb/conv_core_model.sv ====
// behavioural converter core answering every sample with a fixed code
`timescale 1ns/10ps
module conv_core_model (
  // clock
  input wire i_core_clk,
  // control from the block
  input wire i_power,
  input wire i_sample_start,
  // result back to the block
  output logic [9:0] o_result
);
  logic [9:0] held = 10'h000;
  // an unpowered core shows a toggling pattern, never a stale code
  always @(posedge i_core_clk)
    if (!i_power)
      held <= ~held;
    else if (i_sample_start)
      held <= 10'h2c5;
  assign o_result = held;
endmodule // conv_core_model

// ==== tb/conv_ctrl_chk.sv ====
// concurrent checks on the converter control ports
`timescale 1ns/10ps
module conv_ctrl_chk (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_ce,
  // bus
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [31:0] o_wb_dat,
  input wire o_wb_ack,
  // processor and core side
  input wire i_global_irq_en,
  input wire o_done_irq,
  input wire o_conv_power,
  input wire o_conv_clk_tick,
  input wire o_sample_start,
  input wire o_conv_init
);
  // single clock domain, reset blanks every check
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  irq_gate_a: assert property (o_done_irq |-> i_global_irq_en) else $error("irq without global enable");
  start_pow_a: assert property (o_sample_start |-> o_conv_power) else $error("start while off");
  tick_off_a: assert property (!o_conv_power ##1 !o_conv_power |-> !o_conv_clk_tick) else $error("tick while off");
  tick_gap_a: assert property (o_conv_clk_tick |=> !o_conv_clk_tick) else $error("tick faster than half");
  init_pow_a: assert property (o_conv_init |-> o_conv_power) else $error("init while off");
  start_once_a: assert property (o_sample_start |=> !o_sample_start) else $error("start pulse too long");
  ack_once_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
  ack_take_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack && i_ce |=> o_wb_ack) else $error("no ack");
  read_zero_a: assert property (o_wb_ack && !i_wb_we |-> o_wb_dat[31:8] == 24'h0) else $error("upper data set");
endmodule // conv_ctrl_chk

bind conv_ctrl conv_ctrl_chk u_chk (.i_core_clk, .i_rst_n, .i_ce, .i_wb_cyc, .i_wb_stb, .i_wb_we,
  .o_wb_dat, .o_wb_ack, .i_global_irq_en, .o_done_irq, .o_conv_power, .o_conv_clk_tick,
  .o_sample_start, .o_conv_init);

// ==== tb/tb.sv ====
// self-checking bench for the converter control block
`timescale 1ns/10ps
`include "conv_ctrl_regs.vh"
module tb;
  typedef struct { logic [9:0] a; logic [7:0] d; logic [7:0] e; } row_t;
  logic clk, rst_n, cyc, stb, we, ack, ack_mid, gie, vec, irq, pwr, tick, sst, init, diff;
  logic [9:0] adr, res;
  logic [31:0] wdat, rdat, q;
  logic [7:0] trig;
  logic [4:0] csel;
  logic [3:0] pos, neg;
  logic [1:0] gain;
  int err_total, num_checks, tks, last_tks, cnt, gap, n;
  row_t rows [4] = '{'{`ADDR_INPUT_SELECT, 8'h25, 8'h25}, '{`ADDR_TRIGGER_SELECT, 8'h07, 8'h07},
    '{`ADDR_CONTROL_STATUS, 8'h1f, 8'h0f}, '{10'h1f8, 8'hff, 8'h00}};
  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  conv_ctrl u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_global_irq_en(gie), .i_irq_vector_taken(vec), .o_done_irq(irq), .i_trigger_sources(trig),
    .o_conv_power(pwr), .o_conv_clk_tick(tick), .o_sample_start(sst), .o_conv_init(init),
    .o_channel_gain_selector(csel), .o_pos_input(pos), .o_neg_input(neg), .o_gain_code(gain),
    .o_differential(diff), .i_conv_result(res));
  conv_core_model u_core (.i_core_clk(clk), .i_power(pwr), .i_sample_start(sst), .o_result(res));
  // ticks per conversion and system cycles per tick
  always @(posedge clk)
  begin
    tks <= sst ? 0 : tks + (tick ? 1 : 0);
    if ($rose(irq))
      last_tks <= tks + (tick ? 1 : 0);
    cnt <= tick ? 1 : cnt + 1;
    if (tick)
      gap <= cnt;
  end
  // ack seen mid-cycle, so the edge that samples it high is known without a race
  always @(negedge clk)
    ack_mid <= ack;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack_mid !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      check("bus wait", 0, 1);
      print_verdict();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [9:0] a);
    wb(1'b0, a, 8'h00);
  endtask
  // bounded wait for completion, then let counters and decode settle
  task automatic wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000)
    begin
      check("done wait", 0, 1);
      print_verdict();
    end
    repeat (2) @(posedge clk);
  endtask
  initial
  begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 10'h000;
    wdat = 32'h0;
    gie = 1'b0;
    vec = 1'b0;
    trig = 8'h00;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(`ADDR_CONTROL_STATUS);
    check("control reset", q, 32'h0);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      check("register row", q, {24'h0, rows[i].e});
    end
    // every divider code, long enough for two ticks at 128
    for (int i = 0; i < 8; i++)
    begin
      wr(`ADDR_CONTROL_STATUS, 8'h80 | 8'(i));
      repeat (300) @(posedge clk);
      check("tick period", gap, i < 2 ? 2 : 1 << i);
    end
    wr(`ADDR_CONTROL_STATUS, 8'h00);
    wr(`ADDR_TRIGGER_SELECT, 8'h00);
    gie <= 1'b1;
    wr(`ADDR_INPUT_SELECT, 8'h1e);
    wr(`ADDR_CONTROL_STATUS, 8'hc8);
    rd(`ADDR_CONTROL_STATUS);
    check("start busy", q[6], 1'b1);
    check("selector held", csel, 5'h00);
    wr(`ADDR_INPUT_SELECT, 8'h3f);
    wait_irq();
    check("first ticks", last_tks, 25);
    check("selector", csel, 5'h1f);
    check("ground", pos, 4'h9);
    rd(`ADDR_RESULT_HIGH);
    check("left high", q, 32'hb1);
    rd(`ADDR_RESULT_LOW);
    check("left low", q, 32'h40);
    wr(`ADDR_INPUT_SELECT, 8'h1e);
    rd(`ADDR_RESULT_LOW);
    check("right low", q, 32'hc5);
    rd(`ADDR_RESULT_HIGH);
    check("right high", q, 32'h02);
    wr(`ADDR_CONTROL_STATUS, 8'hd8);
    check("flag cleared", irq, 1'b0);
    wait_irq();
    check("later ticks", last_tks, 13);
    check("bandgap", pos, 4'h8);
    vec <= 1'b1;
    @(posedge clk);
    vec <= 1'b0;
    repeat (60) @(posedge clk);
    check("vector clear", irq, 1'b0);
    // free running on a differential pair
    wr(`ADDR_INPUT_SELECT, 8'h0d);
    wr(`ADDR_CONTROL_STATUS, 8'hf8);
    wait_irq();
    check("pair", {diff, gain, pos, neg}, {1'b1, 2'h2, 4'h3, 4'h2});
    wr(`ADDR_CONTROL_STATUS, 8'hb8);
    wait_irq();
    check("free ticks", last_tks, 13);
    gie <= 1'b0;
    repeat (2) @(posedge clk);
    check("irq masked", irq, 1'b0);
    gie <= 1'b1;
    // disable mid conversion
    wr(`ADDR_CONTROL_STATUS, 8'h18);
    @(posedge clk);
    check("power off", pwr, 1'b0);
    repeat (100) @(posedge clk);
    check("no result", irq, 1'b0);
    rd(`ADDR_CONTROL_STATUS);
    check("after abort", q, 32'h08);
    // trigger source 1 rising edge
    wr(`ADDR_TRIGGER_SELECT, 8'h01);
    wr(`ADDR_CONTROL_STATUS, 8'ha8);
    trig <= 8'h02;
    n = 0;
    while (sst !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    check("trigger start", sst, 1'b1);
    check("first init", init, 1'b1);
    wait_irq();
    check("trigger ticks", last_tks, 25);
    // switching to free running with the flag set must not start anything
    wr(`ADDR_TRIGGER_SELECT, 8'h00);
    repeat (20) @(posedge clk);
    rd(`ADDR_CONTROL_STATUS);
    check("free switch", q, 32'hb8);
    print_verdict();
  end
endmodule // tb
